// *** rtl/cuse_defs.vh ***
`ifndef CUSE_DEFS_VH
`define CUSE_DEFS_VH

// Store operation classes
`define CUSE_OP_UNPRIV_CAP 3'h0
`define CUSE_OP_CAP_NORMAL 3'h1
`define CUSE_OP_CAP_ALT 3'h2
`define CUSE_OP_INT_ALT 3'h3
`define CUSE_OP_FP_ALT 3'h4

// Size codes: bytes = 1 << code
`define CUSE_SZ_8 3'h0
`define CUSE_SZ_16 3'h1
`define CUSE_SZ_32 3'h2
`define CUSE_SZ_64 3'h3
`define CUSE_SZ_128 3'h4

// Permission mask bits
`define CUSE_PERM_W 3
`define CUSE_PERM_STORE 3'h1
`define CUSE_PERM_STORE_CAP 3'h2
`define CUSE_PERM_STORE_LOCAL 3'h4

// Capability layout
`define CUSE_CAP_W 129
`define CUSE_CAP_TAG 128
`define CUSE_CAP_LOCAL 127
`define CUSE_CAP_BYTES 5'h10
`define CUSE_CAP_SCALE 4

// Exception levels
`define CUSE_EL0 2'h0
`define CUSE_EL1 2'h1
`define CUSE_EL2 2'h2

// APB register map
`define CUSE_REG_STATUS 12'h000
`define CUSE_REG_MASK 12'h004
`define CUSE_REG_COUNT 12'h008
`define CUSE_REG_CTRL 12'h00C
`define CUSE_EV_W 2
`define CUSE_EV_DONE 0
`define CUSE_EV_FAULT 1

`endif

// *** rtl/cuse_store_exec.v ***
`timescale 1ns/1ns
`include "cuse_defs.vh"
module cuse_store_exec #(
    parameter ADDR_W = 64,
    parameter REG_IDX_W = 5
) (
    input wire clk,
    input wire rst,
    input wire issueValid,
    input wire [2:0] opClass,
    input wire [2:0] sizeCode,
    input wire [8:0] nineBitImmediate,
    input wire [REG_IDX_W-1:0] baseRegisterField,
    input wire [REG_IDX_W-1:0] capabilityTransferField,
    input wire capabilityAddressingModeBit,
    input wire userAccessOverrideBit,
    input wire hostHypervisorEnable,
    input wire trapGeneralExceptions,
    input wire [1:0] currentEl,
    input wire [ADDR_W-1:0] intBaseAddr,
    input wire [`CUSE_CAP_W-1:0] capBaseReg,
    input wire [`CUSE_CAP_W-1:0] capTransferReg,
    input wire [127:0] dataTransferReg,
    input wire checkDone,
    input wire checkOk,
    input wire memDone,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg pready,
    output reg [31:0] prdata,
    output reg pslverr,
    output reg issueReady,
    output reg [REG_IDX_W-1:0] baseSelIdx_r,
    output reg [REG_IDX_W-1:0] capSelIdx_r,
    output reg baseIsCap_r,
    output reg checkReq_r,
    output reg [ADDR_W-1:0] storeAddr_r,
    output reg [4:0] accessBytes_r,
    output reg [`CUSE_PERM_W-1:0] permRequired_r,
    output reg unprivAccess_r,
    output reg [1:0] capCheckEl_r,
    output reg [1:0] accessEl_r,
    output reg memWrite_r,
    output reg storeIsCap_r,
    output reg [`CUSE_CAP_W-1:0] storeData_r,
    output reg faultPulse_r,
    output reg irq_r
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_CHECK = 4'h2;
    localparam [3:0] ST_WRITE = 4'h4;
    localparam [3:0] ST_WAIT = 4'h8;

    reg [3:0] state_r;
    reg [1:0] status_r;
    reg [1:0] mask_r;
    reg [31:0] storeCount_r;
    reg enable_r;
    reg [3:0] state_nxt;

    // Tag and local bits decide the required permission mask
    function [`CUSE_PERM_W-1:0] permFor;
        input [`CUSE_CAP_W-1:0] cap;
        begin
            permFor = `CUSE_PERM_STORE;
            if (cap[`CUSE_CAP_TAG]) begin
                permFor = permFor | `CUSE_PERM_STORE_CAP;
                if (cap[`CUSE_CAP_LOCAL])
                    permFor = permFor | `CUSE_PERM_STORE_LOCAL;
            end
        end
    endfunction

    wire isCapOp = (opClass == `CUSE_OP_UNPRIV_CAP) || (opClass == `CUSE_OP_CAP_NORMAL) ||
        (opClass == `CUSE_OP_CAP_ALT);
    wire isUnpriv = (opClass == `CUSE_OP_UNPRIV_CAP);
    wire [ADDR_W-1:0] immExt = {{(ADDR_W-9){nineBitImmediate[8]}}, nineBitImmediate};
    wire [ADDR_W-1:0] immScaled = {immExt[ADDR_W-1-`CUSE_CAP_SCALE:0], 4'h0};
    wire [ADDR_W-1:0] offset = isUnpriv ? immScaled : immExt;
    // Base kind per form
    reg useCapBase;
    always @* begin
        case (opClass)
            `CUSE_OP_UNPRIV_CAP: useCapBase = capabilityAddressingModeBit;
            `CUSE_OP_CAP_NORMAL: useCapBase = capabilityAddressingModeBit;
            default: useCapBase = ~capabilityAddressingModeBit;
        endcase
    end
    wire [ADDR_W-1:0] baseVa = useCapBase ? capBaseReg[ADDR_W-1:0] : intBaseAddr;
    wire [ADDR_W-1:0] addr = baseVa + offset;
    wire unprivEl1 = (currentEl == `CUSE_EL1);
    wire unprivEl2 = (currentEl == `CUSE_EL2) && hostHypervisorEnable && trapGeneralExceptions;
    wire dropPriv = isUnpriv && !userAccessOverrideBit && (unprivEl1 || unprivEl2);
    reg [4:0] bytes;
    always @* begin
        if (isCapOp)
            bytes = `CUSE_CAP_BYTES;
        else if (opClass == `CUSE_OP_INT_ALT)
            bytes = (sizeCode == `CUSE_SZ_64) ? 5'h08 : 5'h04;
        else
            case (sizeCode)
                `CUSE_SZ_8: bytes = 5'h01;
                `CUSE_SZ_16: bytes = 5'h02;
                `CUSE_SZ_32: bytes = 5'h04;
                `CUSE_SZ_64: bytes = 5'h08;
                default: bytes = 5'h10;
            endcase
    end
    wire [`CUSE_CAP_W-1:0] intData = (opClass == `CUSE_OP_INT_ALT && sizeCode != `CUSE_SZ_64) ?
        {97'h0, dataTransferReg[31:0]} : {1'b0, dataTransferReg};
    wire accept = issueValid && issueReady;

    always @* begin
        case (state_r)
            ST_IDLE: state_nxt = accept ? ST_CHECK : ST_IDLE;
            ST_CHECK: state_nxt = checkDone ? (checkOk ? ST_WRITE : ST_IDLE) : ST_CHECK;
            ST_WRITE: state_nxt = ST_WAIT;
            ST_WAIT: state_nxt = memDone ? ST_IDLE : ST_WAIT;
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Check outcome, only meaningful in the check state
    wire inCheck = (state_r == ST_CHECK);
    wire checkPass = inCheck && checkDone && checkOk;
    wire checkFail = inCheck && checkDone && !checkOk;
    wire writeDone = (state_r == ST_WAIT) && memDone;

    // Store sequencer
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Ready again once idle and enabled
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            issueReady <= 1'b0;
        end else begin
            issueReady <= enable_r && (state_nxt == ST_IDLE);
        end
    end

    // Register file indices taken at acceptance
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            baseSelIdx_r <= {REG_IDX_W{1'b0}};
            capSelIdx_r <= {REG_IDX_W{1'b0}};
        end else if (accept) begin
            baseSelIdx_r <= baseRegisterField;
            capSelIdx_r <= capabilityTransferField;
        end
    end

    // Base kind and store address
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            baseIsCap_r <= 1'b0;
            storeAddr_r <= {ADDR_W{1'b0}};
        end else if (accept) begin
            baseIsCap_r <= useCapBase;
            storeAddr_r <= addr;
        end
    end

    // One-cycle check request
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            checkReq_r <= 1'b0;
        end else begin
            checkReq_r <= accept;
        end
    end

    // Access size and permission mask
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            accessBytes_r <= 5'h00;
            permRequired_r <= {`CUSE_PERM_W{1'b0}};
        end else if (accept) begin
            accessBytes_r <= bytes;
            permRequired_r <= isCapOp ? permFor(capTransferReg) : `CUSE_PERM_STORE;
        end
    end

    // Access privilege and capability check level
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            unprivAccess_r <= 1'b0;
            accessEl_r <= `CUSE_EL0;
            capCheckEl_r <= `CUSE_EL0;
        end else if (accept) begin
            unprivAccess_r <= dropPriv;
            accessEl_r <= dropPriv ? `CUSE_EL0 : currentEl;
            capCheckEl_r <= currentEl;
        end
    end

    // Data to be written
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            storeIsCap_r <= 1'b0;
            storeData_r <= {`CUSE_CAP_W{1'b0}};
        end else if (accept) begin
            storeIsCap_r <= isCapOp;
            storeData_r <= isCapOp ? capTransferReg : intData;
        end
    end

    // Write strobe only after a passed check
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            memWrite_r <= 1'b0;
        end else begin
            memWrite_r <= checkPass;
        end
    end

    // Fault report, memory untouched
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            faultPulse_r <= 1'b0;
        end else begin
            faultPulse_r <= checkFail;
        end
    end

    // Register bus decode
    function regHit;
        input [11:0] a;
        input [11:0] off;
        begin
            regHit = (a == off);
        end
    endfunction

    wire setupPhase = psel && !penable;
    wire apbWr = psel && penable && pwrite && pready;
    wire apbRd = setupPhase && !pwrite;
    wire mapped = regHit(paddr, `CUSE_REG_STATUS) || regHit(paddr, `CUSE_REG_MASK) ||
        regHit(paddr, `CUSE_REG_COUNT) || regHit(paddr, `CUSE_REG_CTRL);
    wire wrStatus = apbWr && regHit(paddr, `CUSE_REG_STATUS);
    wire wrMask = apbWr && regHit(paddr, `CUSE_REG_MASK);
    wire wrCtrl = apbWr && regHit(paddr, `CUSE_REG_CTRL);

    // Sticky events, set wins over write-one-to-clear
    wire [`CUSE_EV_W-1:0] evSet;
    wire [`CUSE_EV_W-1:0] statusClr = wrStatus ? pwdata[`CUSE_EV_W-1:0] : {`CUSE_EV_W{1'b0}};
    wire [`CUSE_EV_W-1:0] statusNext;
    assign evSet[`CUSE_EV_DONE] = writeDone;
    assign evSet[`CUSE_EV_FAULT] = checkFail;
    genvar ev;
    generate
        for (ev = 0; ev < `CUSE_EV_W; ev = ev + 1) begin : g_sticky
            assign statusNext[ev] = evSet[ev] | (status_r[ev] & ~statusClr[ev]);
        end
    endgenerate

    // Read data selection
    reg [31:0] readMux;
    always @* begin
        readMux = 32'h00000000;
        case (paddr)
            `CUSE_REG_STATUS: readMux = {30'h0, status_r};
            `CUSE_REG_MASK: readMux = {30'h0, mask_r};
            `CUSE_REG_COUNT: readMux = storeCount_r;
            `CUSE_REG_CTRL: readMux = {31'h0, enable_r};
            default: readMux = 32'h00000000;
        endcase
    end

    // Ready in the access cycle, no wait states
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= setupPhase;
        end
    end

    // Error for unmapped offsets
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setupPhase && !mapped;
        end
    end

    // Read data captured in the setup cycle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (apbRd) begin
            prdata <= readMux;
        end
    end

    // Event status
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            status_r <= {`CUSE_EV_W{1'b0}};
        end else begin
            status_r <= statusNext;
        end
    end

    // Interrupt mask
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_r <= {`CUSE_EV_W{1'b0}};
        end else if (wrMask) begin
            mask_r <= pwdata[`CUSE_EV_W-1:0];
        end
    end

    // Issue enable
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            enable_r <= 1'b1;
        end else if (wrCtrl) begin
            enable_r <= pwdata[0];
        end
    end

    // Completed store counter
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            storeCount_r <= 32'h00000000;
        end else if (evSet[`CUSE_EV_DONE]) begin
            storeCount_r <= storeCount_r + 32'h00000001;
        end
    end

    // Level interrupt from unmasked status
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(statusNext & mask_r);
        end
    end

    // Spare padding of the sequencer state space is handled by the default branch
endmodule // cuse_store_exec

// *** testbench/cuse_store_exec_assertions.sv ***
`timescale 1ns/1ns
`include "cuse_defs.vh"
module cuse_sva (
    input wire clk,
    input wire rst,
    input wire issueValid,
    input wire issueReady,
    input wire [2:0] opClass,
    input wire [1:0] currentEl,
    input wire userAccessOverrideBit,
    input wire checkDone,
    input wire checkOk,
    input wire checkReq_r,
    input wire [4:0] accessBytes_r,
    input wire [`CUSE_PERM_W-1:0] permRequired_r,
    input wire [1:0] accessEl_r,
    input wire [1:0] capCheckEl_r,
    input wire memWrite_r,
    input wire faultPulse_r,
    input wire storeIsCap_r,
    input wire [`CUSE_CAP_W-1:0] storeData_r,
    input wire [`CUSE_CAP_W-1:0] capTransferReg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_take_check: assert property (issueValid && issueReady |=> checkReq_r && !issueReady)
        else $error("store not launched");
    a_cap_el: assert property (checkReq_r |-> capCheckEl_r == $past(currentEl))
        else $error("capability check level wrong");
    a_unpriv_el1: assert property (checkReq_r && $past(opClass) == 3'h0 && $past(currentEl) == 2'h1
        && !$past(userAccessOverrideBit) |-> accessEl_r == 2'h0)
        else $error("unprivileged level not lowered");
    a_cap_size: assert property (checkReq_r && $past(opClass) < 3'h3 |-> accessBytes_r == 5'h10 && permRequired_r[0])
        else $error("capability size or permission wrong");
    a_data_perm: assert property (checkReq_r && $past(opClass) > 3'h2 |-> permRequired_r == 3'h1)
        else $error("data store permission wrong");
    a_write_ok: assert property (checkDone && checkOk |=> memWrite_r ##1 !memWrite_r)
        else $error("write not issued once");
    a_fault_abort: assert property (checkDone && !checkOk |=> faultPulse_r && !memWrite_r)
        else $error("fault did not abort");
    a_cap_data: assert property (memWrite_r && storeIsCap_r |-> storeData_r == capTransferReg)
        else $error("stored capability wrong");
    c_fault: cover property (faultPulse_r);
    c_unpriv: cover property (checkReq_r && accessEl_r != capCheckEl_r);
    c_write: cover property (memWrite_r && storeIsCap_r);
endmodule // cuse_sva
bind cuse_store_exec cuse_sva sva (.clk(clk), .rst(rst), .issueValid(issueValid), .issueReady(issueReady),
    .opClass(opClass), .currentEl(currentEl), .userAccessOverrideBit(userAccessOverrideBit),
    .checkDone(checkDone), .checkOk(checkOk), .checkReq_r(checkReq_r), .accessBytes_r(accessBytes_r),
    .permRequired_r(permRequired_r), .accessEl_r(accessEl_r), .capCheckEl_r(capCheckEl_r),
    .memWrite_r(memWrite_r), .faultPulse_r(faultPulse_r), .storeIsCap_r(storeIsCap_r),
    .storeData_r(storeData_r), .capTransferReg(capTransferReg));

// *** testbench/cuse_mem_model.sv ***
`timescale 1ns/1ns
module cuse_mem_model (
    input wire clk,
    input wire checkReq,
    input wire memWrite,
    input wire deny,
    input wire [1:0] waitCycles,
    output reg checkDone = 1'b0,
    output reg checkOk = 1'b0,
    output reg memDone = 1'b0
);
    // Check answer, refused on demand
    always @(posedge clk) begin
        if (checkReq) begin
            repeat (waitCycles) @(posedge clk);
            checkDone <= 1'b1;
            checkOk <= !deny;
            @(posedge clk);
            checkDone <= 1'b0;
            checkOk <= deny;
        end
    end
    // Write completion
    always @(posedge clk) begin
        if (memWrite) begin
            repeat (waitCycles) @(posedge clk);
            memDone <= 1'b1;
            @(posedge clk);
            memDone <= 1'b0;
        end
    end
endmodule // cuse_mem_model

// *** testbench/tb.sv ***
`timescale 1ns/1ns
`include "cuse_defs.vh"
module tb;
    reg clk = '0, rst = '1, issueValid = '0, psel = '0, penable = '0, pwrite = '0, deny = '0, rerr;
    reg capabilityAddressingModeBit = '0, userAccessOverrideBit = '0, hostHypervisorEnable = '0;
    reg trapGeneralExceptions = '0;
    reg [2:0] opClass = '0, sizeCode = '0;
    reg [8:0] nineBitImmediate = '0;
    reg [4:0] baseRegisterField = '0, capabilityTransferField = '0;
    reg [1:0] currentEl = '0, waitCycles = '0;
    reg [63:0] intBaseAddr = '0;
    reg [128:0] capBaseReg = '0, capTransferReg = '0;
    reg [127:0] dataTransferReg = '0;
    reg [11:0] paddr = '0;
    reg [31:0] pwdata = '0, rdata;
    reg [88:0] notes[$];
    reg [88:0] note;
    reg [128:0] expData;
    wire checkDone, checkOk, memDone, pready, pslverr, issueReady, baseIsCap_r, checkReq_r, unprivAccess_r;
    wire memWrite_r, storeIsCap_r, faultPulse_r, irq_r;
    wire [31:0] prdata;
    wire [4:0] baseSelIdx_r, capSelIdx_r, accessBytes_r;
    wire [63:0] storeAddr_r;
    wire [2:0] permRequired_r;
    wire [1:0] capCheckEl_r, accessEl_r;
    wire [128:0] storeData_r;
    integer seed = 32'hE343, fails = 0, samples_checked = 0, i;
    cuse_store_exec dut (.clk(clk), .rst(rst), .issueValid(issueValid), .opClass(opClass), .sizeCode(sizeCode),
        .nineBitImmediate(nineBitImmediate), .baseRegisterField(baseRegisterField),
        .capabilityTransferField(capabilityTransferField),
        .capabilityAddressingModeBit(capabilityAddressingModeBit),
        .userAccessOverrideBit(userAccessOverrideBit), .hostHypervisorEnable(hostHypervisorEnable),
        .trapGeneralExceptions(trapGeneralExceptions), .currentEl(currentEl), .intBaseAddr(intBaseAddr),
        .capBaseReg(capBaseReg), .capTransferReg(capTransferReg), .dataTransferReg(dataTransferReg),
        .checkDone(checkDone), .checkOk(checkOk), .memDone(memDone), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .issueReady(issueReady), .baseSelIdx_r(baseSelIdx_r), .capSelIdx_r(capSelIdx_r),
        .baseIsCap_r(baseIsCap_r), .checkReq_r(checkReq_r), .storeAddr_r(storeAddr_r),
        .accessBytes_r(accessBytes_r), .permRequired_r(permRequired_r), .unprivAccess_r(unprivAccess_r),
        .capCheckEl_r(capCheckEl_r), .accessEl_r(accessEl_r), .memWrite_r(memWrite_r),
        .storeIsCap_r(storeIsCap_r), .storeData_r(storeData_r), .faultPulse_r(faultPulse_r), .irq_r(irq_r));
    cuse_mem_model mem (.clk(clk), .checkReq(checkReq_r), .memWrite(memWrite_r), .deny(deny),
        .waitCycles(waitCycles), .checkDone(checkDone), .checkOk(checkOk), .memDone(memDone));
    initial forever #2 clk = ~clk;
    task test_done;
        $display("fails %0d samples_checked %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task lim(input integer k);
        if (k >= 50) begin
            fails = fails + 1;
            $display("[ERR] %0t no answer", $time);
            test_done;
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        integer k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge clk); k = k + 1; end while (pready !== 1'b1 && k < 50);
        lim(k);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task store(input [2:0] op, input [2:0] sz, input [8:0] imm);
        reg [63:0] off;
        reg cap, red;
        integer k;
        @(posedge clk);
        {opClass, sizeCode, nineBitImmediate} <= {op, sz, imm};
        currentEl <= 2'({$random(seed)} % 3);
        {capabilityAddressingModeBit, userAccessOverrideBit, hostHypervisorEnable, trapGeneralExceptions,
            waitCycles, baseRegisterField, capabilityTransferField} <= 16'($random(seed));
        intBaseAddr <= {$random(seed), $random(seed)};
        capBaseReg <= 129'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)});
        capTransferReg <= 129'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)});
        dataTransferReg <= {$random(seed), $random(seed), $random(seed), $random(seed)};
        issueValid <= 1'b1;
        k = 0;
        do begin @(posedge clk); k = k + 1; end while (issueReady !== 1'b1 && k < 50);
        lim(k);
        issueValid <= 1'b0;
        off = {{55{imm[8]}}, imm};
        if (op == `CUSE_OP_UNPRIV_CAP) off = off << `CUSE_CAP_SCALE;
        cap = (op < `CUSE_OP_CAP_ALT) ? capabilityAddressingModeBit : !capabilityAddressingModeBit;
        red = op == `CUSE_OP_UNPRIV_CAP && !userAccessOverrideBit && (currentEl == `CUSE_EL1
            || (currentEl == `CUSE_EL2 && hostHypervisorEnable && trapGeneralExceptions));
        notes.push_back({(cap ? capBaseReg[63:0] : intBaseAddr) + off,
            op < 3 ? `CUSE_CAP_BYTES : op == 3 ? (sz == 3 ? 5'h8 : 5'h4) : 5'h1 << sz,
            op < 3 ? {capTransferReg[128] & capTransferReg[127], capTransferReg[128], 1'b1} : 3'h1,
            red, red ? `CUSE_EL0 : currentEl, currentEl, cap, op < 3, baseRegisterField, capabilityTransferField});
        k = 0;
        do begin @(posedge clk); k = k + 1; end while (issueReady !== 1'b1 && k < 50);
        lim(k);
    endtask
    always @(posedge clk) begin
        if (checkReq_r === 1'b1) begin
            note = notes.pop_front();
            samples_checked = samples_checked + 1;
            expData = (opClass < 3'h3) ? capTransferReg : (opClass == `CUSE_OP_INT_ALT && sizeCode != `CUSE_SZ_64)
                ? {97'h0, dataTransferReg[31:0]} : {1'b0, dataTransferReg};
            if ({storeAddr_r, accessBytes_r, permRequired_r, unprivAccess_r, accessEl_r, capCheckEl_r, baseIsCap_r,
                storeIsCap_r, baseSelIdx_r, capSelIdx_r} !== note
                || storeData_r !== expData) begin
                fails = fails + 1;
                $display("[ERR] %0t store fields want %h", $time, note);
            end
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        chk(issueReady, 0);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        apb(0, `CUSE_REG_STATUS, 0); chk(rdata, 0);
        apb(0, `CUSE_REG_CTRL, 0); chk(rdata, 1);
        apb(0, 12'h010, 0); chk({rerr, rdata[30:0]}, 32'h80000000);
        apb(1, `CUSE_REG_MASK, 32'h3);
        for (i = 0; i < 40; i = i + 1)
            store(3'(i % 5), 3'((i / 5) % 5), i == 0 ? 9'h100 : i == 1 ? 9'h0FF : 9'($random(seed)));
        apb(1, `CUSE_REG_COUNT, 32'hFFFF);
        apb(0, `CUSE_REG_COUNT, 0); chk(rdata, 40);
        apb(0, `CUSE_REG_STATUS, 0); chk({rdata, irq_r}, 32'h3);
        apb(1, `CUSE_REG_STATUS, 32'h1);
        repeat (2) @(posedge clk); chk(irq_r, 0);
        deny <= 1'b1;
        store(`CUSE_OP_CAP_ALT, 0, 0);
        deny <= 1'b0;
        apb(0, `CUSE_REG_COUNT, 0); chk(rdata, 40);
        apb(0, `CUSE_REG_STATUS, 0); chk({rdata, irq_r}, 32'h5);
        apb(1, `CUSE_REG_MASK, 0);
        apb(1, `CUSE_REG_CTRL, 0);
        repeat (2) @(posedge clk); chk({irq_r, issueReady}, 0);
        apb(1, `CUSE_REG_CTRL, 32'h1);
        test_done;
    end
endmodule // tb
